// *** mgm_pkg.sv ***
package mgm_pkg;

    // register byte offsets
    localparam logic [15:0] MGM_OFS_CAPABILITY = 16'h04FC;
    localparam logic [15:0] MGM_OFS_CONFIG     = 16'h0500;
    localparam logic [15:0] MGM_OFS_CONTROL    = 16'h0504;
    localparam logic [15:0] MGM_OFS_WR_VALUE   = 16'h0508;
    localparam logic [15:0] MGM_OFS_RD_VALUE   = 16'h050C;
    localparam logic [15:0] MGM_OFS_IRQ_STATUS = 16'h0600;
    localparam logic [15:0] MGM_OFS_IRQ_PEND   = 16'h0620;
    localparam logic [15:0] MGM_OFS_IRQ_ENABLE = 16'h0640;
    localparam logic [15:0] MGM_OFS_IRQ_CLEAR  = 16'h0660;

    // capability bit positions
    localparam int MGM_CAP_FILTERS_BIT = 10;
    localparam int MGM_CAP_STATS_BIT   = 8;
    localparam int MGM_CAP_1000_BIT    = 2;
    localparam int MGM_CAP_100_BIT     = 1;
    localparam int MGM_CAP_10_BIT      = 0;

    // config field positions
    localparam int MGM_CFG_DIV_LSB = 0;
    localparam int MGM_CFG_DIV_W   = 6;
    localparam int MGM_CFG_EN_BIT  = 6;

    // control field positions
    localparam int MGM_CTL_PHY_LSB    = 24;
    localparam int MGM_CTL_REG_LSB    = 16;
    localparam int MGM_CTL_OP_LSB     = 14;
    localparam int MGM_CTL_LAUNCH_BIT = 11;
    localparam int MGM_CTL_READY_BIT  = 7;

    localparam int MGM_DATA_W  = 16;
    localparam int MGM_IRQ_BIT = 0;

    // reset values
    localparam logic [5:0]  MGM_RST_DIV    = 6'h00;
    localparam logic        MGM_RST_EN     = 1'b0;
    localparam logic [4:0]  MGM_RST_ADDR   = 5'h00;
    localparam logic [1:0]  MGM_RST_OP     = 2'h0;
    localparam logic [15:0] MGM_RST_DATA   = 16'h0000;
    localparam logic        MGM_RST_READY  = 1'b1;

    // opcodes
    localparam logic [1:0] MGM_OP_WRITE = 2'b01;
    localparam logic [1:0] MGM_OP_READ  = 2'b10;

    // frame layout
    localparam int          MGM_FRAME_BITS   = 64;
    localparam logic [31:0] MGM_PREAMBLE     = 32'hFFFF_FFFF;
    localparam logic [1:0]  MGM_START        = 2'b01;
    localparam logic [1:0]  MGM_TURN_WRITE   = 2'b10;
    localparam logic [5:0]  MGM_TURN_IDX     = 6'h2E;
    localparam logic [5:0]  MGM_DATA_IDX     = 6'h30;
    localparam logic [5:0]  MGM_LAST_IDX     = 6'h3F;

    typedef struct packed {
        logic [1:0]  op;
        logic [4:0]  phy;
        logic [4:0]  regi;
        logic [15:0] wdata;
    } mgm_cmd_t;

endpackage : mgm_pkg

// *** mgm_frame.sv ***
`timescale 1ns/1ps
`default_nettype none
module mgm_frame (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              rise_tick,
    input  wire logic              fall_tick,
    input  wire logic              start,
    input  wire mgm_pkg::mgm_cmd_t cmd,
    input  wire logic              mdio_sync,
    output logic                   busy,
    output logic                   done,
    output logic [15:0]            rdata,
    output logic                   mdio_out,
    output logic                   mdio_oe
);
    import mgm_pkg::*;

    typedef enum logic [1:0] {
        MGM_IDLE  = 2'b00,
        MGM_SHIFT = 2'b01,
        MGM_DONE  = 2'b11
    } mgm_state_t;

    mgm_state_t  state_reg,  state_next;
    logic [63:0] shift_reg,  shift_next;
    logic [5:0]  idx_reg,    idx_next;
    logic        fell_reg,   fell_next;
    logic        is_rd_reg,  is_rd_next;
    logic [15:0] rdata_reg,  rdata_next;
    logic        out_reg,    out_next;
    logic        oe_reg,     oe_next;

    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        idx_next   = idx_reg;
        fell_next  = fell_reg;
        is_rd_next = is_rd_reg;
        rdata_next = rdata_reg;
        out_next   = out_reg;
        oe_next    = oe_reg;
        unique case (state_reg)
            MGM_IDLE: begin
                oe_next = 1'b0;
                if (start) begin
                    // full 64-bit frame, preamble first
                    shift_next = {MGM_PREAMBLE, MGM_START, cmd.op, cmd.phy, cmd.regi,
                                  MGM_TURN_WRITE, cmd.wdata};
                    is_rd_next = (cmd.op == MGM_OP_READ);
                    idx_next   = 6'h00;
                    fell_next  = 1'b0;
                    state_next = MGM_SHIFT;
                end
            end
            MGM_SHIFT: begin
                if (fall_tick) begin
                    // drive on falling edge so the phy sees stable data at rise
                    out_next   = shift_reg[63];
                    shift_next = {shift_reg[62:0], 1'b0};
                    oe_next    = !(is_rd_reg && idx_reg >= MGM_TURN_IDX);
                    fell_next  = 1'b1;
                end else if (rise_tick && fell_reg) begin
                    if (is_rd_reg && idx_reg >= MGM_DATA_IDX) begin
                        rdata_next = {rdata_reg[14:0], mdio_sync};
                    end
                    idx_next = idx_reg + 6'h01;
                    if (idx_reg == MGM_LAST_IDX) begin
                        state_next = MGM_DONE;
                    end
                end
            end
            MGM_DONE: begin
                oe_next    = 1'b0;
                out_next   = 1'b1; // idle high, like the released line
                state_next = MGM_IDLE;
            end
            default: state_next = MGM_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= MGM_IDLE;
            shift_reg <= 64'h0000_0000_0000_0000;
            idx_reg   <= 6'h00;
            fell_reg  <= 1'b0;
            is_rd_reg <= 1'b0;
            rdata_reg <= 16'h0000;
            out_reg   <= 1'b1;
            oe_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            idx_reg   <= idx_next;
            fell_reg  <= fell_next;
            is_rd_reg <= is_rd_next;
            rdata_reg <= rdata_next;
            out_reg   <= out_next;
            oe_reg    <= oe_next;
        end
    end

    assign busy     = (state_reg != MGM_IDLE);
    assign done     = (state_reg == MGM_DONE);
    assign rdata    = rdata_reg;
    assign mdio_out = out_reg;
    assign mdio_oe  = oe_reg;

endmodule : mgm_frame
`default_nettype wire

// *** mgm_regs.sv ***
// Behaviour
// - mdc equals clock over 2*(divisor+1)
// - divisor resets zero; zero keeps port disabled
// - config bit 6 enables port, resets 0
// - control holds phy address and register index
// - opcode 01 writes, 10 reads
// - writing launch bit starts a transaction
// - launch bit clears itself after write
// - ready bit shows no frame busy and no launch pending (port enable not included), resets 1
// - control changes apply only in frame gaps
// - read result lands in read value register
// - status bit set by event or 1, cleared by 0
// - pending is status and enable together
// - capability flags fixed by build parameters
// - clear register bit 0 clears status, self-clearing
`timescale 1ns/1ps
`default_nettype none
module mgm_regs #(
    parameter logic CAP_FILTERS = 1'b1,
    parameter logic CAP_STATS   = 1'b1,
    parameter logic CAP_1000    = 1'b1,
    parameter logic CAP_100     = 1'b1,
    parameter logic CAP_10      = 1'b1
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic [31:0]      reg_rdata,
    output logic             reg_rvalid,
    input  wire logic        eth_frame_gap,
    output logic             mdc,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe,
    output logic             mgm_done_irq
);
    import mgm_pkg::*;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // configuration state
    logic [5:0]  div_reg,      div_next;
    logic        en_reg,       en_next;
    // control shadow, written any time
    mgm_cmd_t    shadow_reg,   shadow_next;
    logic        launch_reg,   launch_next;
    // control applied only in a frame gap
    mgm_cmd_t    active_reg,   active_next;
    // op of the frame in flight; active may change in a gap mid-frame
    logic        rd_run_reg,   rd_run_next;
    logic [15:0] wval_reg,     wval_next;
    logic [15:0] rval_reg,     rval_next;
    logic        status_reg,   status_next;
    logic        irq_en_reg,   irq_en_next;
    logic [31:0] rdata_reg,    rdata_next;
    logic        rvalid_reg,   rvalid_next;
    // mdc divider
    logic [5:0]  cnt_reg,      cnt_next;
    logic        mdc_reg,      mdc_next;
    // mdio input synchroniser
    logic        sync1_reg;
    logic        sync2_reg;

    logic        port_on;
    logic        tick;
    logic        rise_tick;
    logic        fall_tick;
    logic        start;
    logic        busy;
    logic        done;
    logic [15:0] frame_rdata;
    logic        ready;
    logic        pending;
    logic        wr_ctl;

    assign port_on   = en_reg && (div_reg != MGM_RST_DIV);
    assign tick      = port_on && (cnt_reg == div_reg);
    assign rise_tick = tick && !mdc_reg;
    assign fall_tick = tick && mdc_reg;
    // a pending launch counts as busy, so launches never queue
    assign ready     = !busy && !launch_reg;
    assign pending   = status_reg && irq_en_reg;
    assign wr_ctl    = reg_wr && hit(reg_addr, MGM_OFS_CONTROL);
    // a launch waits for a gap while the port stays enabled; busy blocks it until done
    assign start     = launch_reg && eth_frame_gap && port_on && !busy;

    // divider: toggle every div+1 clocks for a period of 2*(div+1)
    always_comb begin
        cnt_next = cnt_reg;
        mdc_next = mdc_reg;
        if (!port_on) begin
            // restart from zero so mdc resumes low
            cnt_next = 6'h00;
            mdc_next = 1'b0;
        end else if (tick) begin
            cnt_next = 6'h00;
            mdc_next = !mdc_reg;
        end else begin
            cnt_next = cnt_reg + 6'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 6'h00;
            mdc_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            mdc_reg <= mdc_next;
        end
    end

    // both flops reset to the pulled-up idle level
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= mdio_in;
            sync2_reg <= sync1_reg;
        end
    end

    // register writes and hardware updates
    always_comb begin
        div_next    = div_reg;
        en_next     = en_reg;
        shadow_next = shadow_reg;
        launch_next = launch_reg;
        active_next = active_reg;
        wval_next   = wval_reg;
        rval_next   = rval_reg;
        status_next = status_reg;
        irq_en_next = irq_en_reg;
        rd_run_next = rd_run_reg;
        if (reg_wr) begin
            if (hit(reg_addr, MGM_OFS_CONFIG)) begin
                div_next = reg_wdata[MGM_CFG_DIV_LSB +: MGM_CFG_DIV_W];
                en_next  = reg_wdata[MGM_CFG_EN_BIT];
            end
            if (hit(reg_addr, MGM_OFS_WR_VALUE)) begin
                wval_next = reg_wdata[MGM_DATA_W-1:0];
            end
            // software may overwrite it; the next read frame replaces it
            if (hit(reg_addr, MGM_OFS_RD_VALUE)) begin
                rval_next = reg_wdata[MGM_DATA_W-1:0];
            end
            if (hit(reg_addr, MGM_OFS_IRQ_STATUS)) begin
                status_next = reg_wdata[MGM_IRQ_BIT];
            end
            if (hit(reg_addr, MGM_OFS_IRQ_ENABLE)) begin
                irq_en_next = reg_wdata[MGM_IRQ_BIT];
            end
            if (hit(reg_addr, MGM_OFS_IRQ_CLEAR) && reg_wdata[MGM_IRQ_BIT]) begin
                status_next = 1'b0;
            end
        end
        if (wr_ctl) begin
            shadow_next.phy  = reg_wdata[MGM_CTL_PHY_LSB +: 5];
            shadow_next.regi = reg_wdata[MGM_CTL_REG_LSB +: 5];
            shadow_next.op   = reg_wdata[MGM_CTL_OP_LSB +: 2];
            // a launch on a disabled or busy port is dropped
            if (reg_wdata[MGM_CTL_LAUNCH_BIT] && port_on && ready) begin
                launch_next = 1'b1;
            end
        end
        if (eth_frame_gap) begin
            active_next.phy  = shadow_next.phy;
            active_next.regi = shadow_next.regi;
            active_next.op   = shadow_next.op;
        end
        // write value follows its register; software loads it before launching
        active_next.wdata = wval_reg;
        shadow_next.wdata = wval_reg;
        if (start) begin
            launch_next = 1'b0;
            rd_run_next = (active_next.op == MGM_OP_READ);
        end
        // disabling the port drops a launch still waiting for a gap
        if (!port_on) begin
            launch_next = 1'b0;
        end
        if (done) begin
            status_next = 1'b1; // set beats clear
            if (rd_run_reg) begin
                rval_next = frame_rdata;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg    <= MGM_RST_DIV;
            en_reg     <= MGM_RST_EN;
            shadow_reg <= '{op: MGM_RST_OP, phy: MGM_RST_ADDR, regi: MGM_RST_ADDR,
                            wdata: MGM_RST_DATA};
            launch_reg <= 1'b0;
            active_reg <= '{op: MGM_RST_OP, phy: MGM_RST_ADDR, regi: MGM_RST_ADDR,
                            wdata: MGM_RST_DATA};
            wval_reg   <= MGM_RST_DATA;
            rval_reg   <= MGM_RST_DATA;
            status_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            rd_run_reg <= 1'b0;
        end else begin
            div_reg    <= div_next;
            en_reg     <= en_next;
            shadow_reg <= shadow_next;
            launch_reg <= launch_next;
            active_reg <= active_next;
            wval_reg   <= wval_next;
            rval_reg   <= rval_next;
            status_reg <= status_next;
            irq_en_reg <= irq_en_next;
            rd_run_reg <= rd_run_next;
        end
    end

    // read path: data one cycle after the strobe
    always_comb begin
        rdata_next  = 32'h0000_0000;
        rvalid_next = reg_rd;
        if (reg_rd) begin
            if (hit(reg_addr, MGM_OFS_CAPABILITY)) begin
                rdata_next[MGM_CAP_FILTERS_BIT] = CAP_FILTERS;
                rdata_next[MGM_CAP_STATS_BIT]   = CAP_STATS;
                rdata_next[MGM_CAP_1000_BIT]    = CAP_1000;
                rdata_next[MGM_CAP_100_BIT]     = CAP_100;
                rdata_next[MGM_CAP_10_BIT]      = CAP_10;
            end
            if (hit(reg_addr, MGM_OFS_CONFIG)) begin
                rdata_next[MGM_CFG_DIV_LSB +: MGM_CFG_DIV_W] = div_reg;
                rdata_next[MGM_CFG_EN_BIT]                   = en_reg;
            end
            if (hit(reg_addr, MGM_OFS_CONTROL)) begin
                // launch bit always reads 0
                rdata_next[MGM_CTL_PHY_LSB +: 5]  = shadow_reg.phy;
                rdata_next[MGM_CTL_REG_LSB +: 5]  = shadow_reg.regi;
                rdata_next[MGM_CTL_OP_LSB +: 2]   = shadow_reg.op;
                rdata_next[MGM_CTL_READY_BIT]     = ready;
            end
            if (hit(reg_addr, MGM_OFS_WR_VALUE)) begin
                rdata_next[MGM_DATA_W-1:0] = wval_reg;
            end
            if (hit(reg_addr, MGM_OFS_RD_VALUE)) begin
                rdata_next[MGM_DATA_W-1:0] = rval_reg;
            end
            if (hit(reg_addr, MGM_OFS_IRQ_STATUS)) begin
                rdata_next[MGM_IRQ_BIT] = status_reg;
            end
            if (hit(reg_addr, MGM_OFS_IRQ_PEND)) begin
                rdata_next[MGM_IRQ_BIT] = pending;
            end
            if (hit(reg_addr, MGM_OFS_IRQ_ENABLE)) begin
                rdata_next[MGM_IRQ_BIT] = irq_en_reg;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg  <= 32'h0000_0000;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // cmd is the next value so a gap-time edit reaches the start cycle
    mgm_frame i_mgm_frame (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .rise_tick (rise_tick),
        .fall_tick (fall_tick),
        .start     (start),
        .cmd       (active_next),
        .mdio_sync (sync2_reg),
        .busy      (busy),
        .done      (done),
        .rdata     (frame_rdata),
        .mdio_out  (mdio_out),
        .mdio_oe   (mdio_oe)
    );

    assign mdc          = mdc_reg;
    assign reg_rdata    = rdata_reg;
    assign reg_rvalid   = rvalid_reg;
    assign mgm_done_irq = pending;

endmodule : mgm_regs
`default_nettype wire

// *** mgm_regs_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module mgm_regs_checker
    import mgm_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        eth_frame_gap,
    input wire logic        mdc,
    input wire logic        mdio_in,
    input wire logic        mdio_out,
    input wire logic        mdio_oe,
    input wire logic        mgm_done_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [5:0] div_reg;
    logic       en_reg;
    logic       ena_reg;
    logic [7:0] age_reg;
    logic [6:0] hi_reg;
    logic       cfg_wr;
    logic       st_wr;
    assign cfg_wr = reg_wr && reg_addr == MGM_OFS_CONFIG;
    assign st_wr  = reg_wr && reg_addr == MGM_OFS_IRQ_STATUS;
    // age gates period checks: a divisor change mid-phase gives one odd phase
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 6'h00;
            en_reg  <= 1'b0;
            ena_reg <= 1'b0;
            age_reg <= 8'h00;
            hi_reg  <= 7'h00;
        end else begin
            div_reg <= cfg_wr ? reg_wdata[5:0] : div_reg;
            en_reg  <= cfg_wr ? reg_wdata[6] : en_reg;
            ena_reg <= (reg_wr && reg_addr == MGM_OFS_IRQ_ENABLE) ? reg_wdata[0] : ena_reg;
            age_reg <= cfg_wr ? 8'h00 : ((age_reg == 8'hFF) ? age_reg : age_reg + 8'h01);
            hi_reg  <= mdc ? hi_reg + 7'h01 : 7'h00;
        end
    end
    property p_rd_answer; reg_rd ##1 !reg_rd |-> reg_rvalid ##1 !reg_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
    property p_rd_cause; reg_rvalid |-> $past(reg_rd); endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("read answer unasked");
    property p_rd_idle; !reg_rvalid |-> reg_rdata == 32'h0000_0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_mdc_high; $fell(mdc) && age_reg == 8'hFF |-> hi_reg == {1'b0, div_reg} + 7'h01;
    endproperty
    a_mdc_high: assert property (p_mdc_high) else $error("mdc high phase wrong");
    property p_port_off; age_reg == 8'hFF && (div_reg == 6'h00 || !en_reg) |-> !mdc && !mdio_oe;
    endproperty
    a_port_off: assert property (p_port_off) else $error("disabled port active");
    property p_irq_gate; !ena_reg |-> !mgm_done_irq; endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
    property p_irq_clear;
        reg_wr && reg_addr == MGM_OFS_IRQ_CLEAR && reg_wdata[0] |=> !mgm_done_irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("clear ignored");
    property p_irq_set; st_wr && reg_wdata[0] && ena_reg |=> mgm_done_irq; endproperty
    a_irq_set: assert property (p_irq_set) else $error("status set ignored");
    property p_irq_zero; st_wr && !reg_wdata[0] |=> !mgm_done_irq; endproperty
    a_irq_zero: assert property (p_irq_zero) else $error("status clear ignored");
    property p_oe_span; $rose(mdio_oe) |-> mdio_oe[*8]; endproperty
    a_oe_span: assert property (p_oe_span) else $error("drive too short");
    c_read: cover property (reg_rvalid);
    c_mdc: cover property ($fell(mdc));
    c_irq: cover property ($rose(mgm_done_irq));
endmodule : mgm_regs_checker

bind mgm_regs mgm_regs_checker i_mgm_regs_checker (
    .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .eth_frame_gap(eth_frame_gap), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mgm_done_irq(mgm_done_irq)
);
`default_nettype wire

// *** mgm_phy_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mgm_phy_model
    import mgm_pkg::*;
(
    input  wire logic        mdc,
    input  wire logic        mdio_wire,
    input  wire logic [15:0] rd_value,
    output logic             phy_oe,
    output logic             phy_out,
    output logic [63:0]      frame,
    output logic [7:0]       n_frames
);
    logic [63:0] sr = 64'h0;
    int          cnt = 0;
    logic        is_rd = 1'b0;
    initial begin
        phy_oe = 1'b0;
        phy_out = 1'b0;
        frame = 64'h0;
        n_frames = 8'h00;
    end
    // samples on mdc rise; answers after an output delay like a real part
    always @(posedge mdc) begin
        sr = {sr[62:0], mdio_wire};
        cnt = (cnt != 0) ? cnt + 1 : ((sr[33:0] == {32'hFFFF_FFFF, 2'b01}) ? 34 : 0);
        if (cnt == 36) begin
            is_rd = (sr[1:0] == MGM_OP_READ);
        end
        if (cnt == 64) begin
            frame <= sr;
            n_frames <= n_frames + 8'h01;
            cnt = 0;
        end
        #5;
        phy_oe = is_rd && cnt >= 47;
        phy_out = (cnt > 47) ? rd_value[63 - cnt] : 1'b0;
        is_rd = is_rd && cnt != 0;
    end
endmodule : mgm_phy_model
`default_nettype wire

// *** test_mgm_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_mgm_regs;
    import mgm_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        eth_frame_gap = 1'b1;
    logic [15:0] rd_value = 16'h3C5A;
    logic [31:0] reg_rdata;
    logic        reg_rvalid;
    logic        mdc;
    logic        mdio_in;
    logic        mdio_out;
    logic        mdio_oe;
    logic        mgm_done_irq;
    logic        phy_oe;
    logic        phy_out;
    logic [63:0] frame;
    logic [7:0]  n_frames;
    int          n_fail = 0;
    int          checked = 0;

    always #12.5 core_clk = ~core_clk;
    // line has a pull-up, so a released line reads 1
    assign mdio_in = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'b1);

    mgm_regs #(.CAP_FILTERS(1'b1), .CAP_STATS(1'b0), .CAP_1000(1'b1), .CAP_100(1'b0),
        .CAP_10(1'b1)) i_mgm_regs (
        .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .eth_frame_gap(eth_frame_gap), .mdc(mdc),
        .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mgm_done_irq(mgm_done_irq));
    mgm_phy_model i_mgm_phy_model (.mdc(mdc), .mdio_wire(mdio_in), .rd_value(rd_value),
        .phy_oe(phy_oe), .phy_out(phy_out), .frame(frame), .n_frames(n_frames));

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic rc(input logic [15:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        chk({32'h0, v}, {32'h0, e});
    endtask : rc
    task automatic wait_ready();
        logic [31:0] v;
        v = 32'h0;
        repeat (8) @(posedge core_clk);
        for (int i = 0; i < 2000 && v[7] !== 1'b1; i++) begin
            rd(MGM_OFS_CONTROL, v);
        end
    endtask : wait_ready

    task automatic t_reset();
        rc(MGM_OFS_CAPABILITY, 32'h0000_0405);
        rc(MGM_OFS_CONFIG, 32'h0);
        rc(MGM_OFS_CONTROL, 32'h0000_0080);
        rc(MGM_OFS_WR_VALUE, 32'h0);
        rc(MGM_OFS_RD_VALUE, 32'h0);
        rc(MGM_OFS_IRQ_STATUS, 32'h0);
        rc(MGM_OFS_IRQ_PEND, 32'h0);
        rc(MGM_OFS_IRQ_ENABLE, 32'h0);
        rc(16'h0700, 32'h0);
        wr(MGM_OFS_CAPABILITY, 32'hFFFF_FFFF);
        rc(MGM_OFS_CAPABILITY, 32'h0000_0405);
        $display("test reset values done");
    endtask : t_reset
    task automatic t_disabled();
        wr(MGM_OFS_WR_VALUE, 32'hFFFF_A5C3);
        rc(MGM_OFS_WR_VALUE, 32'h0000_A5C3);
        wr(MGM_OFS_CONTROL, 32'h150A_4800);
        rc(MGM_OFS_CONTROL, 32'h150A_4080);
        wr(MGM_OFS_CONFIG, 32'hFFFF_FFC0);
        rc(MGM_OFS_CONFIG, 32'h0000_0040);
        wr(MGM_OFS_CONTROL, 32'h150A_4800);
        repeat (200) @(posedge core_clk);
        chk({mdc, mdio_oe, n_frames}, 10'h000);
        $display("test disabled port done");
    endtask : t_disabled
    task automatic t_write();
        wr(MGM_OFS_IRQ_ENABLE, 32'h1);
        wr(MGM_OFS_CONFIG, 32'h47);
        eth_frame_gap <= 1'b0;
        wr(MGM_OFS_CONTROL, 32'h150A_4800);
        repeat (300) @(posedge core_clk);
        chk({mdio_oe, n_frames}, 9'h000);
        eth_frame_gap <= 1'b1;
        wait_ready();
        chk(frame, {32'hFFFF_FFFF, 2'b01, MGM_OP_WRITE, 5'h15, 5'h0A, 2'b10, 16'hA5C3});
        chk({n_frames, mgm_done_irq}, 9'h003);
        rc(MGM_OFS_IRQ_PEND, 32'h1);
        wr(MGM_OFS_IRQ_CLEAR, 32'h1);
        rc(MGM_OFS_IRQ_CLEAR, 32'h0);
        rc(MGM_OFS_IRQ_STATUS, 32'h0);
        $display("test phy write done");
    endtask : t_write
    task automatic t_read();
        wr(MGM_OFS_CONFIG, 32'h49);
        wr(MGM_OFS_CONTROL, 32'h011F_8800);
        repeat (8) @(posedge core_clk);
        rc(MGM_OFS_CONTROL, 32'h011F_8000);
        wr(MGM_OFS_CONTROL, 32'h011F_8800);
        wait_ready();
        rc(MGM_OFS_RD_VALUE, 32'h0000_3C5A);
        rc(MGM_OFS_WR_VALUE, 32'h0000_A5C3);
        chk(frame, {32'hFFFF_FFFF, 2'b01, MGM_OP_READ, 5'h01, 5'h1F, 2'b10, rd_value});
        repeat (1500) @(posedge core_clk);
        chk({n_frames, mgm_done_irq}, 9'h005);
        wr(MGM_OFS_IRQ_STATUS, 32'h0);
        rc(MGM_OFS_IRQ_STATUS, 32'h0);
        wr(MGM_OFS_IRQ_STATUS, 32'hFFFF_FFFF);
        rc(MGM_OFS_IRQ_PEND, 32'h1);
        wr(MGM_OFS_IRQ_ENABLE, 32'h0);
        rc(MGM_OFS_IRQ_PEND, 32'h0);
        chk(mgm_done_irq, 1'b0);
        rc(MGM_OFS_IRQ_STATUS, 32'h1);
        $display("test phy read done");
    endtask : t_read

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_disabled();
        t_write();
        t_read();
        final_report();
    end
    // whole run needs under 8000 cycles
    initial begin
        #500000;
        n_fail++;
        $display("ERROR t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
        final_report();
    end
endmodule : test_mgm_regs
`default_nettype wire
